// >>> core/exec_pkg.sv
package exec_pkg;
  localparam int PC_W = 16;
  localparam int OFS_W = 12;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 16'h0000;
  localparam logic [PC_W-1:0] STEP_1 = 16'h0001;
  localparam logic [PC_W-1:0] STEP_2 = 16'h0002;
  localparam logic [PC_W-1:0] STEP_3 = 16'h0003;
  localparam logic [15:0] PROD_RST = 16'h0000;
  localparam logic [7:0] MUL_KEEP = 8'hFC;
  localparam logic [1:0] CYC_1 = 2'h1;
  localparam logic [1:0] CYC_2 = 2'h2;
  localparam logic [1:0] CYC_3 = 2'h3;
  localparam logic [1:0] REG_FLAGS = 2'h0;
  localparam logic [1:0] REG_PC_LO = 2'h1;
  localparam logic [1:0] REG_PC_HI = 2'h2;
  localparam logic [1:0] REG_STATE = 2'h3;

  typedef enum logic [5:0] {
    plain_step, multiply_signed, multiply_signed_by_unsigned,
    fractional_multiply_unsigned, fractional_multiply_signed, fractional_multiply_mixed,
    relative_jump, pointer_jump, relative_call, pointer_call,
    compare_skip_equal, compare_registers, compare_with_carry_in, compare_immediate,
    skip_reg_bit_clear, skip_reg_bit_set, skip_io_bit_clear, skip_io_bit_set,
    branch_flag_set, branch_flag_clear, branch_equal, branch_not_equal,
    branch_carry_set, branch_carry_clear, branch_same_or_higher, branch_lower,
    branch_minus, branch_plus, branch_signed_ge, branch_signed_lt,
    branch_half_carry_set, branch_half_carry_clear, branch_transfer_bit_set,
    branch_transfer_bit_clear, branch_overflow_set, branch_overflow_clear
  } op_e;

  typedef struct packed {
    op_e op;
    logic [2:0] bit_sel;
    logic [OFS_W-1:0] offset;
    logic next_two_word;
    logic [7:0] op_d;
    logic [7:0] op_r;
    logic [7:0] io_val;
    logic [PC_W-1:0] z_ptr;
  } instr_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } bus_req_s;
endpackage : exec_pkg

// >>> core/multiply_branch_skip_unit.sv
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
// Behaviour
// - signed and mixed multiplies write 16-bit product to result pair in 2 cycles
// - fractional multiplies shift the product left one bit, also 2 cycles
// - multiplies touch only zero and carry flags
// - relative jump goes to pc+offset+1, pointer jump to pointer; 2 cycles
// - calls redirect like the matching jumps but take 3 cycles
// - compare-skip-equal advances 2 or 3 on match, else 1
// - register bit skips test one bit and skip on clear or set
// - io bit skips test one io bit and skip on clear or set
// - compares discard the difference, update Z N V C H, take 1 cycle
// - generic flag branch tests selected status bit, target pc+offset+1
// - equal branches on Z set, not-equal on Z clear
// - carry set and lower on C set; carry clear and same-or-higher on C clear
// - minus branches on N set, plus on N clear
// - signed ge branches when N xor V is 0, lt when 1
// - half-carry branches on H set or clear
// - transfer-bit branches on T set or clear
// - overflow branches on V set or clear, flags untouched
module multiply_branch_skip_unit (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire exec_pkg::instr_s instr,
  output logic instr_ready,
  input wire exec_pkg::bus_req_s bus,
  output logic [7:0] rdata,
  output logic [exec_pkg::PC_W-1:0] pc,
  output logic [7:0] flags,
  output logic product_wr,
  output logic [15:0] product,
  output logic push_wr,
  output logic [exec_pkg::PC_W-1:0] push_addr
);
  import exec_pkg::*;

  typedef enum logic {st_idle, st_busy} state_e;

  state_e state;
  state_e next_state;
  logic [1:0] count;
  logic [1:0] next_count;
  logic [1:0] cyc;
  logic [PC_W-1:0] next_pc;
  logic [7:0] next_flags;
  logic [15:0] next_product;
  logic next_product_wr;
  logic next_push_wr;
  logic [PC_W-1:0] next_push_addr;
  logic [7:0] next_rdata;
  logic take;
  logic is_skip;
  logic is_br;
  logic cond;
  logic [PC_W-1:0] seq;
  logic [PC_W-1:0] rel_tgt;
  logic is_frac;
  logic sign_a;
  logic sign_b;
  logic signed [8:0] mul_a;
  logic signed [8:0] mul_b;
  logic signed [17:0] mul_full;
  logic [15:0] mul_raw;
  logic [15:0] mul_res;
  logic cmp_cin;
  logic [8:0] cmp_diff;
  logic [7:0] cmp_res;
  logic [7:0] dv;
  logic [7:0] rv;

  // a new word is only taken while idle; multi-cycle ops hold ready low
  assign take = instr_valid && instr_ready;
  assign seq = pc + STEP_1;
  assign rel_tgt = seq + {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset};
  assign dv = instr.op_d;
  assign rv = instr.op_r;

  // 9-bit signed operands cover both signed and unsigned bytes
  assign is_frac = instr.op inside {fractional_multiply_unsigned, fractional_multiply_signed,
                                    fractional_multiply_mixed};
  assign sign_a = instr.op inside {multiply_signed, multiply_signed_by_unsigned,
                                   fractional_multiply_signed, fractional_multiply_mixed};
  assign sign_b = instr.op inside {multiply_signed, fractional_multiply_signed};
  assign mul_a = {sign_a & dv[7], dv};
  assign mul_b = {sign_b & rv[7], rv};
  assign mul_full = mul_a * mul_b;
  assign mul_raw = mul_full[15:0];
  assign mul_res = is_frac ? {mul_raw[14:0], 1'b0} : mul_raw;

  assign cmp_cin = (instr.op == compare_with_carry_in) ? flags[FLAG_C] : 1'b0;
  assign cmp_diff = {1'b0, dv} - {1'b0, rv} - {8'h00, cmp_cin};
  assign cmp_res = cmp_diff[7:0];

  always_comb begin
    next_pc = pc;
    next_flags = flags;
    next_product = product;
    next_product_wr = 1'b0;
    next_push_wr = 1'b0;
    next_push_addr = push_addr;
    next_state = state;
    next_count = count;
    cyc = CYC_1;
    is_skip = 1'b0;
    is_br = 1'b0;
    cond = 1'b0;
    if (bus.wr) begin
      case (bus.addr)
        REG_FLAGS: next_flags = bus.wdata;
        REG_PC_LO: next_pc[7:0] = bus.wdata;
        REG_PC_HI: next_pc[15:8] = bus.wdata;
        default: ;
      endcase
    end
    // an instruction taken in the same cycle overrides a software pc write and the flag bits it updates
    if (take) begin
      next_pc = seq;
      case (instr.op)
        multiply_signed, multiply_signed_by_unsigned, fractional_multiply_unsigned,
        fractional_multiply_signed, fractional_multiply_mixed: begin
          next_product_wr = 1'b1;
          next_product = mul_res;
          next_flags[FLAG_Z] = (mul_res == PROD_RST);
          next_flags[FLAG_C] = mul_raw[15];
          cyc = CYC_2;
        end
        relative_jump: begin
          next_pc = rel_tgt;
          cyc = CYC_2;
        end
        pointer_jump: begin
          next_pc = instr.z_ptr;
          cyc = CYC_2;
        end
        relative_call, pointer_call: begin
          next_push_wr = 1'b1;
          next_push_addr = seq;
          next_pc = (instr.op == relative_call) ? rel_tgt : instr.z_ptr;
          cyc = CYC_3;
        end
        compare_registers, compare_with_carry_in, compare_immediate: begin
          next_flags[FLAG_Z] = (cmp_res == 8'h00);
          next_flags[FLAG_N] = cmp_res[7];
          next_flags[FLAG_V] = (dv[7] & ~rv[7] & ~cmp_res[7]) | (~dv[7] & rv[7] & cmp_res[7]);
          next_flags[FLAG_C] = cmp_diff[8];
          next_flags[FLAG_H] = (~dv[3] & rv[3]) | (rv[3] & cmp_res[3]) | (cmp_res[3] & ~dv[3]);
        end
        compare_skip_equal: begin
          is_skip = 1'b1;
          cond = (dv == rv);
        end
        skip_reg_bit_clear: begin
          is_skip = 1'b1;
          cond = ~rv[instr.bit_sel];
        end
        skip_reg_bit_set: begin
          is_skip = 1'b1;
          cond = rv[instr.bit_sel];
        end
        skip_io_bit_clear: begin
          is_skip = 1'b1;
          cond = ~instr.io_val[instr.bit_sel];
        end
        skip_io_bit_set: begin
          is_skip = 1'b1;
          cond = instr.io_val[instr.bit_sel];
        end
        branch_flag_set: begin
          is_br = 1'b1;
          cond = flags[instr.bit_sel];
        end
        branch_flag_clear: begin
          is_br = 1'b1;
          cond = ~flags[instr.bit_sel];
        end
        branch_equal, branch_not_equal: begin
          is_br = 1'b1;
          cond = flags[FLAG_Z] ^ (instr.op == branch_not_equal);
        end
        branch_carry_set, branch_lower: begin
          is_br = 1'b1;
          cond = flags[FLAG_C];
        end
        branch_carry_clear, branch_same_or_higher: begin
          is_br = 1'b1;
          cond = ~flags[FLAG_C];
        end
        branch_minus, branch_plus: begin
          is_br = 1'b1;
          cond = flags[FLAG_N] ^ (instr.op == branch_plus);
        end
        branch_signed_ge, branch_signed_lt: begin
          is_br = 1'b1;
          cond = (flags[FLAG_N] ^ flags[FLAG_V]) ^ (instr.op == branch_signed_ge);
        end
        branch_half_carry_set, branch_half_carry_clear: begin
          is_br = 1'b1;
          cond = flags[FLAG_H] ^ (instr.op == branch_half_carry_clear);
        end
        branch_transfer_bit_set, branch_transfer_bit_clear: begin
          is_br = 1'b1;
          cond = flags[FLAG_T] ^ (instr.op == branch_transfer_bit_clear);
        end
        branch_overflow_set, branch_overflow_clear: begin
          is_br = 1'b1;
          cond = flags[FLAG_V] ^ (instr.op == branch_overflow_clear);
        end
        default: ;
      endcase
      if (is_skip && cond) begin
        next_pc = seq + (instr.next_two_word ? STEP_2 : STEP_1);
        cyc = instr.next_two_word ? CYC_3 : CYC_2;
      end
      if (is_br && cond) begin
        next_pc = rel_tgt;
        cyc = CYC_2;
      end
      next_count = cyc - CYC_1;
      next_state = (cyc == CYC_1) ? st_idle : st_busy;
    end else if (state == st_busy) begin
      next_count = count - CYC_1;
      if (count == CYC_1) begin
        next_state = st_idle;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
      count <= 2'h0;
      instr_ready <= 1'b1;
      pc <= PC_RST;
      flags <= FLAGS_RST;
      product <= PROD_RST;
      product_wr <= 1'b0;
      push_wr <= 1'b0;
      push_addr <= PC_RST;
    end else begin
      state <= next_state;
      count <= next_count;
      instr_ready <= (next_state == st_idle);
      pc <= next_pc;
      flags <= next_flags;
      product <= next_product;
      product_wr <= next_product_wr;
      push_wr <= next_push_wr;
      push_addr <= next_push_addr;
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        REG_FLAGS: next_rdata = flags;
        REG_PC_LO: next_rdata = pc[7:0];
        REG_PC_HI: next_rdata = pc[15:8];
        REG_STATE: next_rdata = {5'h00, state == st_busy, count};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  logic [15:0] exp_multiply_signed;
  logic [15:0] exp_fractional_multiply_unsigned;
  logic [PC_W-1:0] exp_ofs;
  assign exp_multiply_signed = {{8{dv[7]}}, dv} * {{8{rv[7]}}, rv};
  assign exp_fractional_multiply_unsigned = ({8'h00, dv} * {8'h00, rv}) << 1;
  // offset extended on its own so target checks do not reuse the datapath sum
  assign exp_ofs = {{(PC_W-OFS_W){instr.offset[OFS_W-1]}}, instr.offset};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_multiply_signed_product: assert property (take && instr.op == multiply_signed
    |=> product_wr && product == $past(exp_multiply_signed) && !instr_ready ##1 instr_ready)
    else $error("signed multiply product or timing wrong");
  a_fractional_multiply_unsigned_shift: assert property (take && instr.op == fractional_multiply_unsigned
    |=> product == $past(exp_fractional_multiply_unsigned) && !instr_ready)
    else $error("fractional multiply not shifted");
  a_mul_flags_kept: assert property (take && is_frac && !bus.wr
    |=> (flags & MUL_KEEP) == ($past(flags) & MUL_KEEP) && flags[FLAG_Z] == (product == PROD_RST))
    else $error("multiply changed other flags");
  a_relative_jump_target: assert property (take && instr.op == relative_jump
    |=> pc == $past(pc) + STEP_1 + $past(exp_ofs) && !instr_ready ##1 instr_ready)
    else $error("relative jump target or timing wrong");
  a_call_push: assert property (take && instr.op == pointer_call
    |=> push_wr && push_addr == $past(pc) + STEP_1 && pc == $past(instr.z_ptr)
    ##0 !instr_ready ##1 !instr_ready ##1 instr_ready)
    else $error("pointer call wrong");
  a_skip_two_word: assert property (take && instr.op == compare_skip_equal && dv == rv
    && instr.next_two_word |=> pc == $past(pc) + STEP_3 ##1 !instr_ready ##1 instr_ready)
    else $error("skip over two words wrong");
  a_bit_noskip: assert property (take && instr.op == skip_reg_bit_set && !rv[instr.bit_sel]
    |=> pc == $past(pc) + STEP_1 && instr_ready)
    else $error("register bit skip taken wrongly");
  a_cmp_one_cycle: assert property (take && instr.op == compare_registers && !bus.wr
    |=> instr_ready && flags[FLAG_Z] == ($past(dv) == $past(rv)))
    else $error("compare flag or timing wrong");
  a_br_untaken: assert property (take && instr.op == branch_equal && !flags[FLAG_Z]
    |=> instr_ready && pc == $past(pc) + STEP_1)
    else $error("untaken equal branch wrong");
  a_br_signed: assert property (take && instr.op == branch_signed_lt && (flags[FLAG_N] ^ flags[FLAG_V])
    |=> pc == $past(pc) + STEP_1 + $past(exp_ofs) && !instr_ready)
    else $error("signed less-than branch wrong");
  a_br_flags_kept: assert property (take && instr.op == branch_overflow_set && !bus.wr
    |=> flags == $past(flags))
    else $error("overflow branch changed flags");

  c_call: cover property (take && instr.op == relative_call);
  c_skip: cover property (take && is_skip && cond);
  c_mul: cover property (take && instr.op == fractional_multiply_mixed);
  c_branch: cover property (take && is_br && cond);
endmodule : multiply_branch_skip_unit

// >>> verif/multiply_branch_skip_unit_bench.sv
`timescale 1ns/1ps
module multiply_branch_skip_unit_bench;
  import exec_pkg::*;
  logic clk, nrst, instr_valid, instr_ready, product_wr, push_wr, pw, sw, t;
  instr_s instr;
  bus_req_s bus;
  logic [7:0] rdata, flags, rv;
  logic [15:0] pc, product, push_addr, p;
  logic [7:0] fv [4] = '{8'h00, 8'hFF, 8'h08, 8'h24};
  int n_fail, compares;

  multiply_branch_skip_unit dut (
    .clk(clk),
    .nrst(nrst),
    .instr_valid(instr_valid),
    .instr(instr),
    .instr_ready(instr_ready),
    .bus(bus),
    .rdata(rdata),
    .pc(pc),
    .flags(flags),
    .product_wr(product_wr),
    .product(product),
    .push_wr(push_wr),
    .push_addr(push_addr)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task end_of_test;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr_reg(input logic [1:0] a, input logic [7:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask : wr_reg

  task rd_reg(input logic [1:0] a);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus <= '0;
    #1 rv = rdata;
  endtask : rd_reg

  // entered just after an edge with instr_ready high; valid drops at the take edge
  task run(input op_e o, input logic [2:0] b, input logic [11:0] k, input logic tw, input logic [7:0] d,
           input logic [7:0] r, input logic [7:0] io, input logic [15:0] z, input int cyc, input logic [15:0] epc);
    int n;
    instr <= '{op: o, bit_sel: b, offset: k, next_two_word: tw, op_d: d, op_r: r, io_val: io, z_ptr: z};
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    pw = product_wr;
    sw = push_wr;
    n = 1;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 8) begin
      n_fail++;
      end_of_test();
    end
    chk(16'(n), 16'(cyc));
    chk(pc, epc);
    p = epc;
  endtask : run

  // pre-set Z and C so a flag that never updates is caught
  task mul(input op_e o, input logic [7:0] d, input logic [7:0] r, input logic [15:0] prod, input logic c);
    wr_reg(REG_FLAGS, 8'hAF);
    run(o, 3'd0, 12'h000, 1'b0, d, r, 8'h00, 16'h0000, 2, p + STEP_1);
    chk(product, prod);
    chk(16'(pw), 16'h0001);
    chk(16'(product_wr), 16'h0000);
    chk(16'(flags), 16'((8'hAF & MUL_KEEP) | {6'h00, prod == 16'h0000, c}));
  endtask : mul

  task cmp(input op_e o, input logic [7:0] pre, input logic [7:0] d, input logic [7:0] r, input logic [7:0] ef);
    wr_reg(REG_FLAGS, pre);
    run(o, 3'd0, 12'h000, 1'b0, d, r, 8'h00, 16'h0000, 1, p + STEP_1);
    chk(16'(flags), 16'(ef));
  endtask : cmp

  function automatic logic taken(input op_e o, input logic [7:0] f, input logic [2:0] b);
    case (o)
      branch_flag_set: return f[b];
      branch_flag_clear: return !f[b];
      branch_equal: return f[FLAG_Z];
      branch_not_equal: return !f[FLAG_Z];
      branch_carry_set, branch_lower: return f[FLAG_C];
      branch_carry_clear, branch_same_or_higher: return !f[FLAG_C];
      branch_minus: return f[FLAG_N];
      branch_plus: return !f[FLAG_N];
      branch_signed_ge: return !(f[FLAG_N] ^ f[FLAG_V]);
      branch_signed_lt: return f[FLAG_N] ^ f[FLAG_V];
      branch_half_carry_set: return f[FLAG_H];
      branch_half_carry_clear: return !f[FLAG_H];
      branch_transfer_bit_set: return f[FLAG_T];
      branch_transfer_bit_clear: return !f[FLAG_T];
      branch_overflow_set: return f[FLAG_V];
      branch_overflow_clear: return !f[FLAG_V];
      default: return 1'b0;
    endcase
  endfunction : taken

  initial begin
    nrst = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    bus = '0;
    n_fail = 0;
    compares = 0;
    p = PC_RST;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    chk(16'(instr_ready), 16'h0001);
    chk(pc, PC_RST);
    chk(16'(flags), 16'(FLAGS_RST));
    chk(product, PROD_RST);
    rd_reg(REG_STATE);
    chk(16'(rv), 16'h0000);
    wr_reg(REG_FLAGS, 8'hA5);
    rd_reg(REG_FLAGS);
    chk(16'(rv), 16'h00A5);
    @(posedge clk);
    #1;
    chk(16'(rdata), 16'h0000);
    $display("test reset and registers done");

    mul(multiply_signed, 8'h80, 8'h80, 16'h4000, 1'b0);
    mul(multiply_signed, 8'h00, 8'h05, 16'h0000, 1'b0);
    mul(multiply_signed_by_unsigned, 8'hFF, 8'hFF, 16'hFF01, 1'b1);
    mul(fractional_multiply_unsigned, 8'hC0, 8'hC0, 16'h2000, 1'b1);
    mul(fractional_multiply_signed, 8'h80, 8'h80, 16'h8000, 1'b0);
    mul(fractional_multiply_mixed, 8'hFF, 8'h02, 16'hFFFC, 1'b1);
    $display("test multiply done");

    cmp(compare_registers, 8'h50, 8'h10, 8'h20, 8'h55);
    cmp(compare_immediate, 8'h00, 8'h80, 8'h01, 8'h28);
    cmp(compare_with_carry_in, 8'hC1, 8'h05, 8'h05, 8'hE5);
    cmp(compare_with_carry_in, 8'h01, 8'h06, 8'h05, 8'h02);
    $display("test compare done");

    wr_reg(REG_PC_LO, 8'h00);
    wr_reg(REG_PC_HI, 8'h01);
    p = 16'h0100;
    run(relative_jump, 3'd0, 12'hFFE, 1'b0, 8'h00, 8'h00, 8'h00, 16'h0000, 2, 16'h00FF);
    run(pointer_jump, 3'd0, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00, 16'h1234, 2, 16'h1234);
    run(relative_call, 3'd0, 12'h010, 1'b0, 8'h00, 8'h00, 8'h00, 16'h0000, 3, 16'h1245);
    chk(16'(sw), 16'h0001);
    chk(16'(push_wr), 16'h0000);
    chk(push_addr, 16'h1235);
    run(pointer_call, 3'd0, 12'h000, 1'b0, 8'h00, 8'h00, 8'h00, 16'h0200, 3, 16'h0200);
    chk(16'(sw), 16'h0001);
    chk(push_addr, 16'h1246);
    rd_reg(REG_PC_HI);
    chk(16'(rv), 16'h0002);
    $display("test jump and call done");

    run(compare_skip_equal, 3'd0, 12'h000, 1'b0, 8'h5A, 8'h5A, 8'h00, 16'h0000, 2, 16'h0202);
    run(compare_skip_equal, 3'd0, 12'h000, 1'b1, 8'h5A, 8'h5A, 8'h00, 16'h0000, 3, 16'h0205);
    run(compare_skip_equal, 3'd0, 12'h000, 1'b1, 8'h5A, 8'h5B, 8'h00, 16'h0000, 1, 16'h0206);
    run(skip_reg_bit_clear, 3'd3, 12'h000, 1'b0, 8'h08, 8'hF7, 8'h08, 16'h0000, 2, 16'h0208);
    run(skip_reg_bit_set, 3'd3, 12'h000, 1'b1, 8'h08, 8'hF7, 8'h08, 16'h0000, 1, 16'h0209);
    run(skip_io_bit_set, 3'd3, 12'h000, 1'b1, 8'hF7, 8'hF7, 8'h08, 16'h0000, 3, 16'h020C);
    run(skip_io_bit_clear, 3'd3, 12'h000, 1'b0, 8'h00, 8'h00, 8'h08, 16'h0000, 1, 16'h020D);
    $display("test skip done");

    // negative offset exercises sign extension of the 12-bit field
    for (int i = int'(branch_flag_set); i <= int'(branch_overflow_clear); i++) begin
      foreach (fv[j]) begin
        wr_reg(REG_FLAGS, fv[j]);
        t = taken(op_e'(i), fv[j], 3'd5);
        run(op_e'(i), 3'd5, 12'hFFD, 1'b0, 8'h00, 8'h00, 8'h00, 16'h0000, t ? 2 : 1, t ? p - STEP_2 : p + STEP_1);
        chk(16'(flags), 16'(fv[j]));
      end
    end
    $display("test branch done");
    end_of_test();
  end
endmodule : multiply_branch_skip_unit_bench
